// ===== verilog/pgfc_defs.svh
// Timing counts, pin indices and function codes for the power group fault control
// Assumes a single 100 MHz system clock shared by both ends
`ifndef PGFC_DEFS_SVH
`define PGFC_DEFS_SVH

// Clock period in ns
`define PGFC_CLK_NS 10
// Spacing between sequence time slots in ns
`define PGFC_SLOT_NS 1000
// Slot spacing in clock cycles, rounded up
`define PGFC_SLOT_CYC ((`PGFC_SLOT_NS + `PGFC_CLK_NS - 1) / `PGFC_CLK_NS)

// Number of general-purpose pins and open-drain outputs
`define PGFC_NUM_GP 11
`define PGFC_NUM_OD 5

// Open-drain output indices
`define PGFC_OD_HOST_INT 0
`define PGFC_OD_MCU_RST 1
`define PGFC_OD_SOC_RST 2
`define PGFC_OD_DDR_RET 3
`define PGFC_OD_GPIO_RET 4

// General-purpose pin indices with fixed roles
`define PGFC_GP_GROUP_SEL 7
`define PGFC_GP_MCU_FAULT 9

// Pin function codes
`define PGFC_FN_GPI 4'h0
`define PGFC_FN_GPO 4'h1
`define PGFC_FN_ALT 4'h2

`endif

// ===== verilog/pgfc_pkg.sv
// Types used by the device end and the testbench of the power group fault control
// Assumes pgfc_defs.svh for all numeric constants
package pgfc_pkg;
    // Power state of the device
    typedef enum logic [3:0] {
        PGFC_OFF,
        PGFC_SAMPLE,
        PGFC_SLOT_MCU,
        PGFC_SLOT_MAIN,
        PGFC_RST_WAIT,
        PGFC_ACTIVE,
        PGFC_MCU_ONLY,
        PGFC_SHUT_MAIN,
        PGFC_SHUT_MCU
    } pgfc_state_e;

    // Function code of one general-purpose pin
    typedef logic [3:0] pgfc_func_t;
endpackage

// ===== verilog/pgfc_if.sv
// Link between the power device and the converters, monitors and host around it
// Assumes open-drain nets with pull-ups; the level is worked out here from the enables
`include "pgfc_defs.svh"
interface pgfc_if;
    // Shared main-group fault net, pulled low by converters or translator
    logic main_net_oe_dev;
    logic main_net_oe_ext;
    logic main_group_fault_net;
    // MCU group fault net, pulled low by the MCU voltage monitor
    logic mcu_net_oe_ext;
    logic mcu_group_fault_net;
    // Regulator rail that powers the converter enable translator
    logic pll_dll_rail;
    // Rail enables from the device
    logic mcu_core_buck;
    logic mcu_rails;
    logic main_rails;
    // Open-drain outputs of the device
    logic [`PGFC_NUM_OD-1:0] od_oe;
    logic [`PGFC_NUM_OD-1:0] od_net;
    // Host pin reassignment request
    logic cfg_valid;
    logic [3:0] cfg_pin;
    logic [3:0] cfg_func;
    logic cfg_ack;
    // Host acknowledge of the interrupt line
    logic int_ack;

    // Pulled-up wires: low while any party enables its driver
    assign main_group_fault_net = ~(main_net_oe_dev | main_net_oe_ext);
    assign mcu_group_fault_net = ~mcu_net_oe_ext;
    assign od_net = ~od_oe;

    modport dev (
        input main_group_fault_net, mcu_group_fault_net, cfg_valid, cfg_pin, cfg_func,
        input int_ack,
        output main_net_oe_dev, pll_dll_rail, mcu_core_buck, mcu_rails, main_rails,
        output od_oe, cfg_ack
    );
    modport ext (
        input main_group_fault_net, pll_dll_rail, mcu_core_buck, mcu_rails, main_rails,
        input od_net, cfg_ack,
        output main_net_oe_ext, mcu_net_oe_ext, cfg_valid, cfg_pin, cfg_func, int_ack
    );
endinterface

// ===== verilog/pgfc_ext.sv
// Far end: converters, voltage monitor, enable translator and host pin setup
// Assumes the device end on the same clock; fault inputs are synchronised here
`include "pgfc_defs.svh"
module pgfc_ext (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic nrst,
    // Link to the device
    pgfc_if.ext lnk,
    // Converter and monitor fault pins, active high
    input wire logic [1:0] conv_fault,
    input wire logic mcu_mon_fault,
    // Host pin reassignment command
    input wire logic req_valid,
    input wire logic [3:0] req_pin,
    input wire logic [3:0] req_func,
    input wire logic req_int_ack,
    output logic req_done,
    // Converter enables seen on the shared net
    output logic conv_en,
    // Device outputs seen by the host
    output logic mcu_por_n,
    output logic host_int_n
);
    // Two-stage synchronisers for the fault pins
    logic [1:0] cf_s1;
    logic [1:0] cf_s2;
    logic mf_s1;
    logic mf_s2;
    // Pending request registers
    logic busy;

    // Synchronise external fault pins
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            cf_s1 <= 2'h0;
            cf_s2 <= 2'h0;
            mf_s1 <= 1'h0;
            mf_s2 <= 1'h0;
        end else begin
            cf_s1 <= conv_fault;
            cf_s2 <= cf_s1;
            mf_s1 <= mcu_mon_fault;
            mf_s2 <= mf_s1;
        end
    end

    // Translator holds the net low until its rail is up; faults pull it low
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            lnk.main_net_oe_ext <= 1'h1;
            lnk.mcu_net_oe_ext <= 1'h0;
        end else begin
            lnk.main_net_oe_ext <= ~lnk.pll_dll_rail | (|cf_s2);
            lnk.mcu_net_oe_ext <= mf_s2;
        end
    end

    // Net low disables the converters
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            conv_en <= 1'h0;
            mcu_por_n <= 1'h0;
            host_int_n <= 1'h1;
        end else begin
            conv_en <= lnk.main_group_fault_net & lnk.main_rails;
            mcu_por_n <= lnk.od_net[`PGFC_OD_MCU_RST];
            host_int_n <= lnk.od_net[`PGFC_OD_HOST_INT];
        end
    end

    // Hold a reassignment request until the device acknowledges it
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            busy <= 1'h0;
            lnk.cfg_valid <= 1'h0;
            lnk.cfg_pin <= 4'h0;
            lnk.cfg_func <= 4'h0;
            req_done <= 1'h0;
            lnk.int_ack <= 1'h0;
        end else begin
            req_done <= 1'h0;
            lnk.int_ack <= req_int_ack;
            if (busy && lnk.cfg_ack) begin
                busy <= 1'h0;
                lnk.cfg_valid <= 1'h0;
                req_done <= 1'h1;
            end else if (!busy && req_valid) begin
                // Any requested pin and function is sent; no pin is filtered here
                busy <= 1'h1;
                lnk.cfg_valid <= 1'h1;
                lnk.cfg_pin <= req_pin;
                lnk.cfg_func <= req_func;
            end
        end
    end
endmodule

// ===== verilog/pgfc_dev.sv
// Device end: power state control driven by the two group fault inputs
// Assumes the far end on the same clock; the two fault nets are synchronised here
`include "pgfc_defs.svh"
module pgfc_dev (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic nrst,
    // Link to the far end
    pgfc_if.dev lnk,
    // Power request from the user, high to power up
    input wire logic pwr_req,
    // Power state and grouping
    output pgfc_pkg::pgfc_state_e state,
    output logic isolated,
    // One-cycle error events
    output logic main_err_evt,
    output logic mcu_err_evt,
    // Current function of each general-purpose pin
    output logic [4*`PGFC_NUM_GP-1:0] pin_func
);
    // Slot counter and its load value
    localparam logic [15:0] SLOT_LOAD = 16'(`PGFC_SLOT_CYC);
    logic [15:0] slot_cnt;
    logic slot_done;
    // Synchronisers for the two fault nets
    logic sel_s1;
    logic sel_s2;
    logic mflt_s1;
    logic mflt_s2;
    // Next state
    pgfc_pkg::pgfc_state_e next_state;
    // Sticky interrupt line state
    logic int_pend;
    // Error conditions
    logic main_err;
    logic mcu_err;

    // Default function of a pin after power-up
    function automatic pgfc_pkg::pgfc_func_t dflt_func(input int idx);
        if (idx == `PGFC_GP_GROUP_SEL || idx == `PGFC_GP_MCU_FAULT) begin
            dflt_func = `PGFC_FN_GPI;
        end else if (idx == 8) begin
            dflt_func = `PGFC_FN_GPO;
        end else begin
            dflt_func = `PGFC_FN_ALT;
        end
    endfunction

    // True while the main group is powered and running
    function automatic logic main_up(input pgfc_pkg::pgfc_state_e s);
        main_up = (s == pgfc_pkg::PGFC_RST_WAIT) || (s == pgfc_pkg::PGFC_ACTIVE);
    endfunction

    // Two flip-flops before any logic reads the nets
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            sel_s1 <= 1'h1;
            sel_s2 <= 1'h1;
            mflt_s1 <= 1'h1;
            mflt_s2 <= 1'h1;
        end else begin
            sel_s1 <= lnk.main_group_fault_net;
            sel_s2 <= sel_s1;
            mflt_s1 <= lnk.mcu_group_fault_net;
            mflt_s2 <= mflt_s1;
        end
    end

    // Errors are only honoured once the relevant group is up
    assign main_err = (state == pgfc_pkg::PGFC_ACTIVE) && !sel_s2 && !isolated_n_grp();
    assign mcu_err = ((state == pgfc_pkg::PGFC_ACTIVE) ||
                      (state == pgfc_pkg::PGFC_MCU_ONLY)) && !mflt_s2;
    assign slot_done = (slot_cnt == 16'h0);

    // Always false: a low select counts as a main fault whether isolation is on or off
    function automatic logic isolated_n_grp();
        isolated_n_grp = 1'b0;
    endfunction

    // Power state transitions
    always_comb begin
        next_state = state;
        unique case (state)
            pgfc_pkg::PGFC_OFF: begin
                if (pwr_req) begin
                    next_state = pgfc_pkg::PGFC_SAMPLE;
                end
            end
            pgfc_pkg::PGFC_SAMPLE: begin
                next_state = pgfc_pkg::PGFC_SLOT_MCU;
            end
            pgfc_pkg::PGFC_SLOT_MCU: begin
                if (slot_done) begin
                    next_state = pgfc_pkg::PGFC_SLOT_MAIN;
                end
            end
            pgfc_pkg::PGFC_SLOT_MAIN: begin
                if (slot_done) begin
                    next_state = pgfc_pkg::PGFC_RST_WAIT;
                end
            end
            pgfc_pkg::PGFC_RST_WAIT: begin
                if (slot_done) begin
                    next_state = pgfc_pkg::PGFC_ACTIVE;
                end
            end
            pgfc_pkg::PGFC_ACTIVE: begin
                // MCU error outranks the main error
                if (mcu_err || !pwr_req) begin
                    next_state = pgfc_pkg::PGFC_SHUT_MAIN;
                end else if (main_err) begin
                    next_state = pgfc_pkg::PGFC_MCU_ONLY;
                end
            end
            pgfc_pkg::PGFC_MCU_ONLY: begin
                if (mcu_err || !pwr_req) begin
                    next_state = pgfc_pkg::PGFC_SHUT_MAIN;
                end
            end
            pgfc_pkg::PGFC_SHUT_MAIN: begin
                if (slot_done) begin
                    next_state = pgfc_pkg::PGFC_SHUT_MCU;
                end
            end
            pgfc_pkg::PGFC_SHUT_MCU: begin
                if (slot_done) begin
                    next_state = pgfc_pkg::PGFC_OFF;
                end
            end
            default: begin
                next_state = pgfc_pkg::PGFC_OFF;
            end
        endcase
    end

    // State register
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            state <= pgfc_pkg::PGFC_OFF;
        end else begin
            state <= next_state;
        end
    end

    // Slot timer restarts on every state change
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            slot_cnt <= 16'h0;
        end else if (next_state != state) begin
            slot_cnt <= SLOT_LOAD - 16'h1;
        end else if (!slot_done) begin
            slot_cnt <= slot_cnt - 16'h1;
        end
    end

    // Group select sampled once as power-up begins
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            isolated <= 1'h1;
        end else if (state == pgfc_pkg::PGFC_SAMPLE) begin
            isolated <= !sel_s2;
        end
    end

    // Rail enables per sequence slot
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            lnk.mcu_rails <= 1'h0;
            lnk.mcu_core_buck <= 1'h0;
            lnk.main_rails <= 1'h0;
            lnk.pll_dll_rail <= 1'h0;
            lnk.main_net_oe_dev <= 1'h0;
        end else begin
            lnk.mcu_rails <= (next_state != pgfc_pkg::PGFC_OFF) &&
                             (next_state != pgfc_pkg::PGFC_SAMPLE);
            // Buck only in isolated grouping
            lnk.mcu_core_buck <= isolated && (next_state != pgfc_pkg::PGFC_OFF) &&
                                 (next_state != pgfc_pkg::PGFC_SAMPLE);
            lnk.main_rails <= (next_state == pgfc_pkg::PGFC_SLOT_MAIN) || main_up(next_state);
            // Same slot as CPU and core rails
            lnk.pll_dll_rail <= (next_state == pgfc_pkg::PGFC_SLOT_MAIN) ||
                                main_up(next_state);
            lnk.main_net_oe_dev <= 1'h0;
        end
    end

    // Error events, one cycle each
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            main_err_evt <= 1'h0;
            mcu_err_evt <= 1'h0;
        end else begin
            main_err_evt <= (state == pgfc_pkg::PGFC_ACTIVE) &&
                            (next_state == pgfc_pkg::PGFC_MCU_ONLY);
            mcu_err_evt <= mcu_err && (next_state == pgfc_pkg::PGFC_SHUT_MAIN);
        end
    end

    // Interrupt line: set wins over the host acknowledge
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            int_pend <= 1'h0;
        end else if (main_err || mcu_err) begin
            int_pend <= 1'h1;
        end else if (lnk.int_ack) begin
            int_pend <= 1'h0;
        end
    end

    // Open-drain outputs: enable means pulling the net low
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            lnk.od_oe <= {`PGFC_NUM_OD{1'b1}};
        end else begin
            lnk.od_oe[`PGFC_OD_HOST_INT] <= int_pend | main_err | mcu_err;
            lnk.od_oe[`PGFC_OD_MCU_RST] <= !((next_state == pgfc_pkg::PGFC_ACTIVE) ||
                                           (next_state == pgfc_pkg::PGFC_MCU_ONLY));
            lnk.od_oe[`PGFC_OD_SOC_RST] <= next_state != pgfc_pkg::PGFC_ACTIVE;
            lnk.od_oe[`PGFC_OD_DDR_RET] <= 1'h1;
            lnk.od_oe[`PGFC_OD_GPIO_RET] <= 1'h1;
        end
    end

    // Pin function table: defaults at power-up, host changes after boot
    genvar gi;
    generate
        for (gi = 0; gi < `PGFC_NUM_GP; gi++) begin : g_pin
            always_ff @(posedge sys_clk) begin
                if (!nrst || state == pgfc_pkg::PGFC_OFF) begin
                    pin_func[4*gi +: 4] <= dflt_func(gi);
                end else if (lnk.cfg_valid && !lnk.cfg_ack && state == pgfc_pkg::PGFC_ACTIVE &&
                             lnk.cfg_pin == 4'(gi)) begin
                    pin_func[4*gi +: 4] <= lnk.cfg_func;
                end
            end
        end
    endgenerate

    // Acknowledge a request once it has been applied
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            lnk.cfg_ack <= 1'h0;
        end else begin
            lnk.cfg_ack <= lnk.cfg_valid && !lnk.cfg_ack &&
                           (state == pgfc_pkg::PGFC_ACTIVE);
        end
    end
endmodule

// ===== verif/pgfc_checker.sv
// Checker for the link between the power device and its far end
// Assumes one clock and a synchronous active-low reset shared by both ends
`include "pgfc_defs.svh"
module pgfc_checker (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic nrst,
    // Link nets and rails
    input wire logic main_group_fault_net,
    input wire logic mcu_group_fault_net,
    input wire logic pll_dll_rail,
    input wire logic mcu_core_buck,
    input wire logic mcu_rails,
    input wire logic main_rails,
    input wire logic [`PGFC_NUM_OD-1:0] od_oe,
    // Pin setup handshake
    input wire logic cfg_valid,
    input wire logic cfg_ack
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    // Buck only runs while the MCU group is up
    AST_BUCK_IN_MCU: assert property (
        mcu_core_buck |-> mcu_rails) else $error("mcu buck on without mcu rails");
    // Main group comes one full slot after the MCU group
    AST_MAIN_AFTER_MCU: assert property (
        $rose(main_rails) |-> $past(mcu_rails, 100)) else $error("main rails too early");
    // Regulator rail shares the main slot
    AST_PLL_SLOT: assert property (
        $rose(main_rails) |-> $rose(pll_dll_rail)) else $error("pll rail not in main slot");
    // Resets release together when active is reached
    AST_RESETS_TOGETHER: assert property (
        $fell(od_oe[1]) |-> !od_oe[2] && main_rails) else $error("resets not released together");
    // Main fault net low while active drops the main group
    AST_MAIN_FAULT: assert property (
        $fell(main_group_fault_net) && !od_oe[2] |-> ##[1:5] (!main_rails && od_oe[2] && od_oe[0]))
        else $error("main fault not handled");
    // MCU fault while the MCU reset is released starts shutdown
    AST_MCU_FAULT: assert property (
        $fell(mcu_group_fault_net) && !od_oe[1] |-> ##[1:5] (od_oe[1] && !main_rails))
        else $error("mcu fault not handled");
    // Orderly shutdown keeps MCU rails for a while after reset
    AST_MCU_RAILS_LATE: assert property (
        $rose(od_oe[1]) |-> mcu_rails [*8]) else $error("mcu rails dropped with reset");
    // Retention enables stay pulled low
    AST_RET_HELD: assert property (
        od_oe[4:3] == 2'b11) else $error("retention outputs released");
    // Setup acknowledge is a single pulse on a live request
    AST_CFG_ACK: assert property (
        cfg_ack |-> cfg_valid ##1 !cfg_ack) else $error("bad setup acknowledge");
    // Main scenarios reached
    cover property ($fell(main_group_fault_net) && !od_oe[2]);
    cover property ($fell(mcu_group_fault_net) && !od_oe[1]);
    cover property (cfg_ack);
endmodule

// ===== verif/power_group_fault_control_tb_top.sv
// Testbench joining the device end and the far end through the link
// Assumes the design's defaults: 100 cycle slots, default isolated build
`include "pgfc_defs.svh"
module power_group_fault_control_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    // Clock, reset and user side stimulus
    logic sys_clk = 1'b0;
    logic nrst = 1'b0;
    logic pwr_req = 1'b0;
    logic [1:0] conv_fault = 2'h0;
    logic mcu_mon_fault = 1'b0;
    logic req_valid = 1'b0;
    logic [3:0] req_pin = 4'h0;
    logic [3:0] req_func = 4'h0;
    logic req_int_ack = 1'b0;
    // Observed outputs
    pgfc_pkg::pgfc_state_e state;
    logic isolated, main_err_evt, mcu_err_evt;
    logic [4*`PGFC_NUM_GP-1:0] pin_func;
    logic req_done, conv_en, mcu_por_n, host_int_n;
    // Counters
    int n_mismatch = 0;
    int comparisons = 0;

    pgfc_if pgfc_if_i ();
    // Free-running 100 MHz clock
    always #5 sys_clk = ~sys_clk;

    pgfc_dev pgfc_dev_i (.sys_clk(sys_clk), .nrst(nrst), .lnk(pgfc_if_i.dev),
        .pwr_req(pwr_req), .state(state), .isolated(isolated), .main_err_evt(main_err_evt),
        .mcu_err_evt(mcu_err_evt), .pin_func(pin_func));
    pgfc_ext pgfc_ext_i (.sys_clk(sys_clk), .nrst(nrst), .lnk(pgfc_if_i.ext),
        .conv_fault(conv_fault), .mcu_mon_fault(mcu_mon_fault), .req_valid(req_valid),
        .req_pin(req_pin), .req_func(req_func), .req_int_ack(req_int_ack),
        .req_done(req_done), .conv_en(conv_en), .mcu_por_n(mcu_por_n),
        .host_int_n(host_int_n));
    pgfc_checker pgfc_checker_i (.sys_clk(sys_clk), .nrst(nrst),
        .main_group_fault_net(pgfc_if_i.main_group_fault_net),
        .mcu_group_fault_net(pgfc_if_i.mcu_group_fault_net),
        .pll_dll_rail(pgfc_if_i.pll_dll_rail), .mcu_core_buck(pgfc_if_i.mcu_core_buck),
        .mcu_rails(pgfc_if_i.mcu_rails), .main_rails(pgfc_if_i.main_rails),
        .od_oe(pgfc_if_i.od_oe), .cfg_valid(pgfc_if_i.cfg_valid), .cfg_ack(pgfc_if_i.cfg_ack));

    // Compare and count
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask
    // Advance n edges, then settle
    task automatic step(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    // Count edges until a state is reached, bounded
    task automatic wait_state(input pgfc_pkg::pgfc_state_e s, output int n);
        n = 0;
        while (state !== s && n < 1000) begin
            step(1);
            n++;
        end
    endtask
    // Wait for the main (0) or MCU (1) error pulse, bounded
    task automatic wait_evt(input bit mcu);
        int k;
        k = 0;
        while ((mcu ? mcu_err_evt : main_err_evt) !== 1'b1 && k < 40) begin
            step(1);
            k++;
        end
        check(k < 40, 1'b1);
    endtask
    // Default pin functions
    function automatic logic [4*`PGFC_NUM_GP-1:0] dflt();
        logic [4*`PGFC_NUM_GP-1:0] f;
        for (int i = 0; i < `PGFC_NUM_GP; i++) begin
            f[4*i +: 4] = `PGFC_FN_ALT;
        end
        f[4*`PGFC_GP_GROUP_SEL +: 4] = `PGFC_FN_GPI;
        f[4*`PGFC_GP_MCU_FAULT +: 4] = `PGFC_FN_GPI;
        f[4*8 +: 4] = `PGFC_FN_GPO;
        return f;
    endfunction
    // One pin setup request from the host
    task automatic cfg(input logic [3:0] pin, input logic [3:0] func);
        int k;
        req_valid = 1'b1;
        req_pin = pin;
        req_func = func;
        step(1);
        req_valid = 1'b0;
        k = 0;
        while (req_done !== 1'b1 && k < 20) begin
            step(1);
            k++;
        end
        check(k < 20, 1'b1);
    endtask

    // Idle after reset; MCU fault ignored while off
    task automatic t_defaults();
        check(state, pgfc_pkg::PGFC_OFF);
        check(pin_func, dflt());
        // Interrupt line rests released; resets and retention enables held low
        check(pgfc_if_i.od_net, 5'h01);
        check(conv_en, 1'b0);
        mcu_mon_fault = 1'b1;
        step(8);
        check(state, pgfc_pkg::PGFC_OFF);
        mcu_mon_fault = 1'b0;
        step(4);
        $display("test defaults done");
    endtask
    // Power up through all slots into active
    task automatic t_power_up();
        int n;
        pwr_req = 1'b1;
        wait_state(pgfc_pkg::PGFC_ACTIVE, n);
        check(n, 302);
        check(isolated, 1'b1);
        check(pgfc_if_i.mcu_core_buck, 1'b1);
        check(pgfc_if_i.pll_dll_rail, 1'b1);
        step(3);
        check(mcu_por_n, 1'b1);
        check(conv_en, 1'b1);
        $display("test power_up done");
    endtask
    // Host reassigns a pin, then names a pin that does not exist
    task automatic t_reconfig();
        logic [4*`PGFC_NUM_GP-1:0] exp;
        exp = dflt();
        exp[4*3 +: 4] = `PGFC_FN_GPO;
        cfg(4'h3, `PGFC_FN_GPO);
        check(pin_func, exp);
        cfg(4'hc, `PGFC_FN_GPI);
        check(pin_func, exp);
        $display("test reconfig done");
    endtask
    // Converter fault pulls the shared net low
    task automatic t_main_fault();
        conv_fault = 2'h1;
        wait_evt(1'b0);
        check(state, pgfc_pkg::PGFC_MCU_ONLY);
        check(pgfc_if_i.main_rails, 1'b0);
        check(pgfc_if_i.mcu_rails, 1'b1);
        step(2);
        check(conv_en, 1'b0);
        check(host_int_n, 1'b0);
        conv_fault = 2'h0;
        $display("test main_fault done");
    endtask
    // Monitor fault starts the orderly shutdown
    task automatic t_mcu_fault();
        int n;
        mcu_mon_fault = 1'b1;
        wait_evt(1'b1);
        pwr_req = 1'b0;
        check(state, pgfc_pkg::PGFC_SHUT_MAIN);
        check(pgfc_if_i.mcu_rails, 1'b1);
        wait_state(pgfc_pkg::PGFC_OFF, n);
        check(n, 200);
        check(mcu_por_n, 1'b0);
        // Defaults are reloaded on the first edge spent in the off state
        step(1);
        check(pin_func, dflt());
        mcu_mon_fault = 1'b0;
        $display("test mcu_fault done");
    endtask

    // Verdict and end of run
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // Main sequence
    initial begin
        step(10);
        nrst = 1'b1;
        step(2);
        t_defaults();
        t_power_up();
        t_reconfig();
        t_main_fault();
        t_mcu_fault();
        final_report();
    end
    // Watchdog well beyond the expected run
    initial begin
        repeat (20000) @(posedge sys_clk);
        n_mismatch++;
        final_report();
    end
endmodule
